// ==== src/anpnp_pkg.sv ====
// Purpose: Constants for the partner next-page received register block
// Assumes: Avalon-MM slave, 32-bit data, byte addresses = 4 * index
// Notes: Register is read-only; writes are accepted and discarded
//
// Contract
// R1 - Read-only 16-bit partner next-page register, index 0x0008
// R2 - Bit 15 more-pages flag, resets 0
// R3 - Bit 14 partner acknowledge, resets 0
// R4 - Acknowledge updated only by negotiation logic
// R5 - Bit 13 message-page flag, resets 1
// R6 - Bit 12 partner can comply, resets 0
// R7 - Bit 11 toggle, inverse of previous toggle
// R8 - Bits 10:0 received page code field
// R9 - Code field resets to null page, one
// R10 - All fields load together per accepted page
package anpnp_pkg;
  localparam logic [7:0] ANPNP_IDX_PARTNER_NP = 8'h08;
  localparam logic [9:0] ANPNP_ADDR_PARTNER_NP = {ANPNP_IDX_PARTNER_NP, 2'b00};
  localparam int ANPNP_BIT_MORE_PAGES = 15;
  localparam int ANPNP_BIT_ACK = 14;
  localparam int ANPNP_BIT_MSG_PAGE = 13;
  localparam int ANPNP_BIT_CAN_COMPLY = 12;
  localparam int ANPNP_BIT_TOGGLE = 11;
  localparam int ANPNP_CODE_W = 11;
  localparam int ANPNP_CODE_LSB = 0;
  localparam logic [15:0] ANPNP_RESET_VAL = 16'h2001;
  localparam logic [31:0] ANPNP_UNMAPPED_VAL = 32'h0000_0000;
  localparam logic [31:0] ANPNP_RDATA_RESET = 32'h0000_0000;
  typedef enum logic [1:0] {
    ANPNP_IDLE = 2'b00,
    ANPNP_RESP = 2'b01
  } anpnp_bus_st_t;
endpackage

// ==== src/anpnp_reg.sv ====
// Purpose: Partner next-page received register with Avalon-MM read port
// Assumes: Page strobe is one cycle, word valid in the same cycle
// Notes: Reads answer one cycle after request; writes answer at once
// Notes: Each field is its own register, loaded together from one page
// Notes: Write data and byte enables are not used; the register is read-only
//
// The implementer's own choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module anpnp_reg
  import anpnp_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Avalon-MM slave
  input wire logic [9:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Received page from negotiation logic
  input wire logic page_valid_i,
  input wire logic [15:0] page_word_i,
  // Status
  output logic [15:0] partner_next_page_received_o
);

  ////////////////////////////////////////////////////////////////////////
  // Page fields, one register per field
  logic more_pages_q;
  logic more_pages_d;

  logic ack_q;
  logic ack_d;

  logic msg_page_q;
  logic msg_page_d;

  logic can_comply_q;
  logic can_comply_d;

  logic toggle_q;
  logic toggle_d;

  logic [ANPNP_CODE_W-1:0] code_q;
  logic [ANPNP_CODE_W-1:0] code_d;

  // Fields put back into register layout
  logic [15:0] page_w;

  // Bus side
  anpnp_bus_st_t st_q;
  anpnp_bus_st_t st_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic read_take;
  logic addr_ok;

  ////////////////////////////////////////////////////////////////////////
  // Address decode for the one mapped register
  function automatic logic addr_hit(input logic [9:0] a);
    addr_hit = (a == ANPNP_ADDR_PARTNER_NP); // [R1]
  endfunction

  // One flag out of a page word
  function automatic logic field_bit(input logic [15:0] w, input int pos);
    field_bit = w[pos];
  endfunction

  // Code field out of a page word
  function automatic logic [ANPNP_CODE_W-1:0] code_of(input logic [15:0] w);
    code_of = w[ANPNP_CODE_LSB +: ANPNP_CODE_W];
  endfunction

  // Upper half of the bus word is always zero
  function automatic logic [31:0] bus_word(input logic hit, input logic [15:0] w);
    if (hit) begin
      bus_word = {16'h0000, w};
    end else begin
      bus_word = ANPNP_UNMAPPED_VAL;
    end
  endfunction

  function automatic logic [15:0] pack_page(
    input logic np,
    input logic ak,
    input logic mp,
    input logic cc,
    input logic tg,
    input logic [ANPNP_CODE_W-1:0] cd
  );
    logic [15:0] w;
    w = 16'h0000;
    w[ANPNP_BIT_MORE_PAGES] = np;
    w[ANPNP_BIT_ACK] = ak;
    w[ANPNP_BIT_MSG_PAGE] = mp;
    w[ANPNP_BIT_CAN_COMPLY] = cc;
    w[ANPNP_BIT_TOGGLE] = tg;
    w[ANPNP_CODE_LSB +: ANPNP_CODE_W] = cd;
    pack_page = w;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // More-pages flag: 1 when the partner has further pages to send
  always_comb begin
    if (page_valid_i) begin
      more_pages_d = field_bit(page_word_i, ANPNP_BIT_MORE_PAGES); // [R2] [R10]
    end else begin
      more_pages_d = more_pages_q;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      more_pages_q <= field_bit(ANPNP_RESET_VAL, ANPNP_BIT_MORE_PAGES); // [R2]
    end else begin
      more_pages_q <= more_pages_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Partner acknowledge; bus writes never reach it, only received pages
  always_comb begin
    if (page_valid_i) begin
      ack_d = field_bit(page_word_i, ANPNP_BIT_ACK); // [R3] [R4] [R10]
    end else begin
      ack_d = ack_q;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      ack_q <= field_bit(ANPNP_RESET_VAL, ANPNP_BIT_ACK); // [R3]
    end else begin
      ack_q <= ack_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Message-page flag: 1 for a message page, 0 for unformatted
  always_comb begin
    if (page_valid_i) begin
      msg_page_d = field_bit(page_word_i, ANPNP_BIT_MSG_PAGE); // [R5] [R10]
    end else begin
      msg_page_d = msg_page_q;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      msg_page_q <= field_bit(ANPNP_RESET_VAL, ANPNP_BIT_MSG_PAGE); // [R5]
    end else begin
      msg_page_q <= msg_page_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Partner can comply with the message
  always_comb begin
    if (page_valid_i) begin
      can_comply_d = field_bit(page_word_i, ANPNP_BIT_CAN_COMPLY); // [R6] [R10]
    end else begin
      can_comply_d = can_comply_q;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      can_comply_q <= field_bit(ANPNP_RESET_VAL, ANPNP_BIT_CAN_COMPLY); // [R6]
    end else begin
      can_comply_q <= can_comply_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Toggle as received; negotiation logic already supplies the inverse
  // of the previous word, so no second inversion here
  always_comb begin
    if (page_valid_i) begin
      toggle_d = field_bit(page_word_i, ANPNP_BIT_TOGGLE); // [R7] [R10]
    end else begin
      toggle_d = toggle_q;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      toggle_q <= field_bit(ANPNP_RESET_VAL, ANPNP_BIT_TOGGLE); // [R7]
    end else begin
      toggle_q <= toggle_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Code field; meaning depends on the message-page flag, left to software
  always_comb begin
    if (page_valid_i) begin
      code_d = code_of(page_word_i); // [R8] [R10]
    end else begin
      code_d = code_q;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      code_q <= code_of(ANPNP_RESET_VAL); // [R9]
    end else begin
      code_q <= code_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    page_w = pack_page(more_pages_q, ack_q, msg_page_q, can_comply_q, toggle_q, code_q);
  end

  ////////////////////////////////////////////////////////////////////////
  // Read is taken only from idle, so one read gets exactly one wait
  assign read_take = avs_read_i && (st_q == ANPNP_IDLE);
  assign addr_ok = addr_hit(avs_address_i); // [R1]

  always_comb begin
    st_d = st_q;
    case (st_q)
      ANPNP_IDLE: begin
        if (read_take) begin
          st_d = ANPNP_RESP;
        end
      end
      ANPNP_RESP: begin
        st_d = ANPNP_IDLE;
      end
      default: begin
        st_d = ANPNP_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      st_q <= ANPNP_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data captured at take; it stands until the next read
  always_comb begin
    case (st_q)
      ANPNP_IDLE: begin
        if (read_take) begin
          rdata_d = bus_word(addr_ok, page_w); // [R1]
        end else begin
          rdata_d = rdata_q;
        end
      end
      default: begin
        rdata_d = rdata_q;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      rdata_q <= ANPNP_RDATA_RESET;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Writes finish at once and change nothing: the register is read-only
  always_comb begin
    case (st_q)
      ANPNP_IDLE: begin
        avs_waitrequest_o = avs_read_i;
      end
      ANPNP_RESP: begin
        avs_waitrequest_o = 1'b0;
      end
      default: begin
        avs_waitrequest_o = avs_read_i;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs straight from registers
  assign avs_readdata_o = rdata_q;
  assign partner_next_page_received_o = page_w;

endmodule

// ==== test/anpnp_monitor.sv ====
// Purpose: register checks; Assumes: sync reset; Notes: bound below
`timescale 1ns/1ps
module anpnp_monitor (input wire logic ref_clk_i, rst_i, avs_read_i, avs_waitrequest_o,
  page_valid_i, input wire logic [15:0] page_word_i, partner_next_page_received_o);
  wire [15:0] r = partner_next_page_received_o;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  pg_ld_a: assert property (page_valid_i |=> r == $past(page_word_i)) else $error("load");
  pg_hold_a: assert property (!page_valid_i |=> $stable(r)) else $error("hold");
  rd_go_a: assert property ($rose(avs_read_i) |-> avs_waitrequest_o) else $error("go");
  rd_wt_a: assert property (avs_waitrequest_o |=> !avs_waitrequest_o) else $error("wait");
  bus_idle_a: assert property (!avs_read_i |-> !avs_waitrequest_o) else $error("idle");
  rst_val_a: assert property ($fell(rst_i) |-> r == 16'h2001) else $error("reset value");
endmodule
bind anpnp_reg anpnp_monitor anpnp_monitor_inst (.*);

// ==== test/anpnp_partner.sv ====
// Purpose: link partner; Assumes: called after an edge; Notes: idle word inverted
`timescale 1ns/1ps
module anpnp_partner (input wire logic ref_clk_i, output logic pv_o = 1'b0,
  output logic [15:0] pw_o = 16'h0000);
  logic t = 1'b0;
  task automatic send(input logic [15:0] d);
    pv_o <= 1'b1;
    pw_o <= {d[15:12], t, d[10:0]};
    t <= !t;
    @(posedge ref_clk_i);
    // Stale word must not look valid
    pv_o <= 1'b0;
    pw_o <= ~pw_o;
  endtask
endmodule

// ==== test/anpnp_reg_tb_top.sv ====
// Purpose: register bench; Assumes: 250 MHz clock; Notes: readback via bus
`timescale 1ns/1ps
module anpnp_reg_tb_top import anpnp_pkg::*; ;
  logic ref_clk_i = 0, rst_i = 1, rd = 0, wr = 0, wt, pv, t = 0;
  logic [9:0] ad = 0;
  logic [15:0] pw, pg[3] = '{16'h8000, 16'h5fff, 16'h2801};
  logic [31:0] rq;
  logic [15:0] so;
  int error_cnt = 0, n_compared = 0;
  initial forever #2 ref_clk_i = !ref_clk_i;
  initial #9999 tally_and_finish(1);
  anpnp_reg anpnp_reg_inst (.ref_clk_i, .rst_i, .avs_address_i(ad), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i('1), .avs_byteenable_i(4'hf), .avs_readdata_o(rq),
    .avs_waitrequest_o(wt), .page_valid_i(pv), .page_word_i(pw), .partner_next_page_received_o(so));
  anpnp_partner anpnp_partner_inst (.ref_clk_i, .pv_o(pv), .pw_o(pw));
  task automatic acc(input logic w, input logic [9:0] a, input logic [15:0] e);
    logic [31:0] q;
    ad <= a;
    rd <= !w;
    wr <= w;
    do begin
      @(posedge ref_clk_i);
    end while (wt !== 1'b0);
    q = rq;
    rd <= 1'b0;
    wr <= 1'b0;
    if (!w) begin
      n_compared++;
      if (q !== {16'h0000, e}) begin
        error_cnt++;
        $display("CHECK FAILED readdata exp %h got %h", {16'h0000, e}, q);
      end
    end
    @(posedge ref_clk_i);
  endtask
  task automatic chk_st(input logic [15:0] e);
    n_compared++;
    if (so !== e) begin
      error_cnt++;
      $display("CHECK FAILED status exp %h got %h", e, so);
    end
  endtask
  task automatic tally_and_finish(int x);
    error_cnt += x;
    if (error_cnt == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge ref_clk_i);
    rst_i <= 0;
    acc(1'b1, ANPNP_ADDR_PARTNER_NP, 16'h0000);
    acc(1'b0, ANPNP_ADDR_PARTNER_NP, 16'h2001);
    chk_st(16'h2001);
    acc(1'b0, 10'h024, 16'h0000);
    foreach (pg[i]) begin
      anpnp_partner_inst.send(pg[i]);
      acc(1'b0, ANPNP_ADDR_PARTNER_NP, {pg[i][15:12], t, pg[i][10:0]});
      chk_st({pg[i][15:12], t, pg[i][10:0]});
      t = !t;
    end
    // Reset in mid-run must bring back the null page
    rst_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    acc(1'b0, ANPNP_ADDR_PARTNER_NP, 16'h2001);
    tally_and_finish(0);
  end
endmodule
